//--- src/ccg_card_clock_gate.sv
// Card clock idle gating and card pin-state control.
// Assumes the controller core presents its command and data drive on the
// system clock and raises busy while any transfer is pending or running.
`timescale 1ns/1ps
module ccg_card_clock_gate #(
   parameter int unsigned HALF_CYCLES = ccg_pkg::DIV_DEFAULT,
   parameter int unsigned IDLE_COUNT  = ccg_pkg::IDLE_CYCLES
) (
   input  wire logic                            mclk_i,
   input  wire logic                            reset_i,
   input  wire logic                            low_power_en_i,
   input  wire logic                            card_busy_i,
   input  wire logic                            cmd_out_i,
   input  wire logic                            cmd_oe_i,
   input  wire logic [ccg_pkg::DATA_WIDTH-1:0]  data_out_i,
   input  wire logic [ccg_pkg::DATA_WIDTH-1:0]  data_oe_i,
   output logic                                 card_clock_line_o,
   output logic                                 card_command_line_o,
   output logic                                 card_command_line_oe_o,
   output logic [ccg_pkg::DATA_WIDTH-1:0]       card_data_lines_o,
   output logic [ccg_pkg::DATA_WIDTH-1:0]       card_data_lines_oe_o,
   output logic                                 clock_gated_o,
   output logic                                 card_ready_o
);
   localparam int unsigned IW = $clog2(IDLE_COUNT + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Card clock generation.

   logic tick;
   logic clk_level;
   logic next_clk_level;
   ccg_pkg::ccg_state_t state;
   ccg_pkg::ccg_state_t next_state;
   logic [IW-1:0] idle_count;
   logic [IW-1:0] next_idle_count;

   ccg_divider #(
      .HALF_CYCLES (HALF_CYCLES)
   ) u_div (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .run_i   (1'b1),
      .tick_o  (tick)
   );

   // A rising tick while low completes a cycle on the next falling tick.
   wire rise_tick = tick && !clk_level;
   wire fall_tick = tick && clk_level;

   ////////////////////////////////////////////////////////////////////////////
   // Idle gating state machine.

   always_comb begin
      next_state = state;
      case (state)
         ccg_pkg::CCG_RUN: begin
            // The counter holds eight falling edges; the next one closes the
            // eighth whole idle cycle, and gating there parks the line low.
            if (low_power_en_i && !card_busy_i && fall_tick &&
                idle_count == IW'(IDLE_COUNT)) begin
               next_state = ccg_pkg::CCG_GATED;
            end
         end
         ccg_pkg::CCG_GATED: begin
            if (card_busy_i || !low_power_en_i) begin
               next_state = ccg_pkg::CCG_WAKE;
            end
         end
         ccg_pkg::CCG_WAKE: begin
            if (rise_tick) begin
               next_state = ccg_pkg::CCG_RUN;
            end
         end
         default: begin
            next_state = ccg_pkg::CCG_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state <= ccg_pkg::CCG_RUN;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Idle time counter.

   // Counts falling card clock edges while the card is idle in low-power mode.
   always_comb begin
      next_idle_count = idle_count;
      if (state != ccg_pkg::CCG_RUN) begin
         next_idle_count = '0;
      end else if (card_busy_i || !low_power_en_i) begin
         next_idle_count = '0;
      end else if (fall_tick && idle_count != IW'(IDLE_COUNT)) begin
         next_idle_count = idle_count + IW'(1);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         idle_count <= '0;
      end else begin
         idle_count <= next_idle_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Card clock level.

   always_comb begin
      next_clk_level = clk_level;
      case (state)
         ccg_pkg::CCG_RUN: begin
            if (tick) begin
               next_clk_level = !clk_level;
            end
         end
         ccg_pkg::CCG_GATED: begin
            next_clk_level = ccg_pkg::CLK_LINE_IDLE;
         end
         ccg_pkg::CCG_WAKE: begin
            // Restart on a rising tick so the first high phase is full width.
            if (rise_tick) begin
               next_clk_level = 1'b1;
            end
         end
         default: begin
            next_clk_level = ccg_pkg::CLK_LINE_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         clk_level <= ccg_pkg::CLK_LINE_IDLE;
      end else begin
         clk_level <= next_clk_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock pin and status drive.

   logic next_clk_o;
   logic next_gated;
   logic next_ready;

   always_comb begin
      next_clk_o = clk_level;
      next_gated = 1'b0;
      next_ready = 1'b1;
      if (next_state != ccg_pkg::CCG_RUN) begin
         next_clk_o = ccg_pkg::CLK_LINE_IDLE;
         next_gated = 1'b1;
         next_ready = 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         card_clock_line_o <= ccg_pkg::CLK_LINE_IDLE;
         clock_gated_o     <= 1'b0;
         card_ready_o      <= 1'b0;
      end else begin
         card_clock_line_o <= next_clk_o;
         clock_gated_o     <= next_gated;
         card_ready_o      <= next_ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command pin drive.

   logic next_cmd_o;
   logic next_cmd_oe;

   // The core's drive is overridden until the clock runs again.
   always_comb begin
      next_cmd_o  = cmd_out_i;
      next_cmd_oe = cmd_oe_i;
      if (next_state != ccg_pkg::CCG_RUN) begin
         next_cmd_o  = ccg_pkg::CMD_LINE_PARKED;
         next_cmd_oe = 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         card_command_line_o    <= 1'b0;
         card_command_line_oe_o <= 1'b0;
      end else begin
         card_command_line_o    <= next_cmd_o;
         card_command_line_oe_o <= next_cmd_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data pin drive, one slice per data line.

   genvar bit_idx;
   generate
      for (bit_idx = 0; bit_idx < ccg_pkg::DATA_WIDTH; bit_idx++) begin : g_data_pin
         logic next_dat_o;
         logic next_dat_oe;

         always_comb begin
            next_dat_o  = data_out_i[bit_idx];
            next_dat_oe = data_oe_i[bit_idx];
            if (next_state != ccg_pkg::CCG_RUN) begin
               next_dat_o  = 1'b0;
               next_dat_oe = 1'b0;
            end
         end

         always_ff @(posedge mclk_i) begin
            if (reset_i) begin
               card_data_lines_o[bit_idx]    <= 1'b0;
               card_data_lines_oe_o[bit_idx] <= 1'b0;
            end else begin
               card_data_lines_o[bit_idx]    <= next_dat_o;
               card_data_lines_oe_o[bit_idx] <= next_dat_oe;
            end
         end
      end
   endgenerate
endmodule // ccg_card_clock_gate

//--- src/ccg_divider.sv
// Card clock divider: produces one-cycle enables for the card clock edges.
// Assumes the divide count is at least one system cycle per half period.
`timescale 1ns/1ps
module ccg_divider #(
   parameter int unsigned HALF_CYCLES = ccg_pkg::DIV_DEFAULT
) (
   input  wire logic mclk_i,
   input  wire logic reset_i,
   input  wire logic run_i,
   output logic      tick_o
);
   localparam int unsigned CW = $clog2(HALF_CYCLES + 1);
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic          next_tick;

   always_comb begin
      next_count = count;
      next_tick  = 1'b0;
      if (run_i) begin
         if (count == CW'(HALF_CYCLES - 1)) begin
            next_count = '0;
            next_tick  = 1'b1;
         end else begin
            next_count = count + CW'(1);
         end
      end else begin
         next_count = '0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         count  <= '0;
         tick_o <= 1'b0;
      end else begin
         count  <= next_count;
         tick_o <= next_tick;
      end
   end
endmodule // ccg_divider

//--- src/ccg_pkg.sv
// Constants for the card clock idle gating block.
// Assumes a single 100 MHz system clock and a synchronous active-high reset.
// Function
// - Low-power bit enables idle clock gating
// - Stop clock after eight idle cycles
// - Gated: clock 0, command 1, data floating
// - Reset: clock 0, command and data floating
package ccg_pkg;
   localparam int unsigned IDLE_CYCLES      = 8;
   localparam int unsigned DIV_DEFAULT      = 4;
   localparam int unsigned DATA_WIDTH       = 4;
   localparam logic        CLK_LINE_IDLE    = 1'b0;
   localparam logic        CMD_LINE_PARKED  = 1'b1;

   typedef enum logic [2:0] {
      CCG_RUN   = 3'b001,
      CCG_GATED = 3'b010,
      CCG_WAKE  = 3'b100
   } ccg_state_t;
endpackage

//--- testbench/ccg_card_model.sv
// Card side model: resolves the card lines and counts card clock rising edges.
// Assumes the card lines carry pull-ups, so a released line reads high.
`timescale 1ns/1ps
module ccg_card_model (
   input  wire logic        clk_line_i,
   input  wire logic        cmd_i,
   input  wire logic        cmd_oe_i,
   input  wire logic [3:0]  data_i,
   input  wire logic [3:0]  data_oe_i,
   output logic             cmd_wire_o,
   output logic [3:0]       data_wire_o,
   output logic [15:0]      edges_o
);
   assign cmd_wire_o = cmd_oe_i ? cmd_i : 1'b1;
   assign data_wire_o = (data_i & data_oe_i) | ~data_oe_i;
   initial edges_o = 16'h0000;
   always @(posedge clk_line_i) begin
      edges_o <= edges_o + 16'h0001;
   end
endmodule // ccg_card_model

//--- testbench/ccg_gate_monitor.sv
// Checker for the card clock gate: pin levels, idle time before gating, wake time.
// Assumes it is bound to the gate with the default half period of four cycles.
`timescale 1ns/1ps
module ccg_gate_monitor (
   input wire logic                           mclk_i,
   input wire logic                           reset_i,
   input wire logic                           low_power_en_i,
   input wire logic                           card_busy_i,
   input wire logic                           card_clock_line_o,
   input wire logic                           card_command_line_o,
   input wire logic                           card_command_line_oe_o,
   input wire logic [ccg_pkg::DATA_WIDTH-1:0] card_data_lines_oe_o,
   input wire logic                           clock_gated_o,
   input wire logic                           card_ready_o
);
   logic [7:0] idle_cnt;
   logic [7:0] next_idle_cnt;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   always_comb begin
      next_idle_cnt = (idle_cnt == 8'hFF) ? idle_cnt : idle_cnt + 8'h01;
      if (reset_i || !low_power_en_i || card_busy_i) next_idle_cnt = 8'h00;
   end
   always_ff @(posedge mclk_i) begin
      idle_cnt <= next_idle_cnt;
   end
   a_reset_pins: assert property (disable iff (1'b0) reset_i |=>
      !card_clock_line_o && !card_command_line_oe_o && card_data_lines_oe_o == 4'h0)
      else $error("pins not parked during reset");
   a_gated_pins: assert property (clock_gated_o |-> !card_clock_line_o &&
      card_command_line_o && card_command_line_oe_o && card_data_lines_oe_o == 4'h0)
      else $error("pins wrong while clock gated");
   a_gate_only_lp: assert property ($rose(clock_gated_o) |-> $past(low_power_en_i, 2))
      else $error("clock gated without low power enable");
   a_idle_min: assert property ($rose(clock_gated_o) |-> idle_cnt >= 8'h40)
      else $error("clock gated before eight idle card cycles");
   a_gate_bound: assert property (idle_cnt == 8'h50 |-> clock_gated_o)
      else $error("idle clock not gated in time");
   a_wake_ready: assert property (card_busy_i && clock_gated_o |-> ##[1:14] card_ready_o)
      else $error("gated clock not resumed in time");
endmodule // ccg_gate_monitor

//--- testbench/tb_ccg_card_clock_gate.sv
// Testbench for the card clock gate: reset levels, gating, override and wake.
// Assumes default parameters: half period of four cycles, eight idle card cycles.
`timescale 1ns/1ps
module tb_ccg_card_clock_gate;
   logic mclk_i = 1'b0, reset_i = 1'b1, low_power_en_i = 1'b0, card_busy_i = 1'b0;
   logic cmd_out_i = 1'b0, cmd_oe_i = 1'b1;
   logic [3:0] data_out_i = 4'h0, data_oe_i = 4'hF;
   wire card_clock_line_o, card_command_line_o, card_command_line_oe_o;
   wire clock_gated_o, card_ready_o, cmd_wire;
   wire [3:0] card_data_lines_o, card_data_lines_oe_o, dat_wire;
   wire [15:0] edges;
   int num_errors = 0, total_checks = 0;
   always #5 mclk_i = ~mclk_i;
   ccg_card_clock_gate ccg_card_clock_gate_inst (.mclk_i, .reset_i, .low_power_en_i,
      .card_busy_i, .cmd_out_i, .cmd_oe_i, .data_out_i, .data_oe_i, .card_clock_line_o,
      .card_command_line_o, .card_command_line_oe_o, .card_data_lines_o,
      .card_data_lines_oe_o, .clock_gated_o, .card_ready_o);
   ccg_card_model ccg_card_model_inst (.clk_line_i(card_clock_line_o),
      .cmd_i(card_command_line_o), .cmd_oe_i(card_command_line_oe_o),
      .data_i(card_data_lines_o), .data_oe_i(card_data_lines_oe_o), .cmd_wire_o(cmd_wire),
      .data_wire_o(dat_wire), .edges_o(edges));
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wait_on(input bit on_ready, output int n);
      for (n = 0; n < 400 && (on_ready ? card_ready_o : clock_gated_o) !== 1'b1; n++)
         @(negedge mclk_i);
      if (n == 400) begin
         num_errors++;
         end_sim();
      end
   endtask
   task automatic t_reset;
      reset_i = 1'b1;
      repeat (16) @(negedge mclk_i);
      chk("reset pins", {card_clock_line_o, card_command_line_oe_o, card_data_lines_oe_o,
         cmd_wire, dat_wire}, 16'h001F);
      reset_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      $display("reset test done");
   endtask
   task automatic t_no_lp;
      low_power_en_i = 1'b0;
      repeat (150) @(negedge mclk_i);
      chk("gated and ready", {clock_gated_o, card_ready_o}, 16'h0001);
      $display("disabled test done");
   endtask
   task automatic t_gate;
      int n;
      int e;
      low_power_en_i = 1'b1;
      wait_on(1'b0, n);
      chk("idle cycles", 16'(n >= 64 && n <= 76), 16'h0001);
      @(negedge mclk_i);
      chk("gated pins", {card_clock_line_o, cmd_wire, card_command_line_oe_o,
         card_data_lines_oe_o, card_ready_o, dat_wire}, 16'h060F);
      e = edges;
      repeat (100) @(negedge mclk_i);
      chk("card edges", edges, 16'(e));
      $display("gating test done");
   endtask
   task automatic t_wake;
      int n;
      card_busy_i = 1'b1;
      wait_on(1'b1, n);
      chk("wake cycles", 16'(n <= 12), 16'h0001);
      repeat (2) @(negedge mclk_i);
      chk("running pins", {clock_gated_o, cmd_wire, card_data_lines_oe_o, dat_wire},
         16'h00F0);
      card_busy_i = 1'b0;
      $display("wake test done");
   endtask
   initial begin
      t_reset();
      t_no_lp();
      t_gate();
      t_wake();
      t_gate();
      t_reset();
      end_sim();
   end
endmodule // tb_ccg_card_clock_gate
bind ccg_card_clock_gate ccg_gate_monitor ccg_gate_monitor_inst (.mclk_i, .reset_i,
   .low_power_en_i, .card_busy_i, .card_clock_line_o, .card_command_line_o,
   .card_command_line_oe_o, .card_data_lines_oe_o, .clock_gated_o, .card_ready_o);
